// ==== core/sbs_sequencer.v ====
// Stepper bridge sequencer for four configurable half bridges
`timescale 1ns/1ps
`include "sbs_regs.vh"
// Notes on behaviour
// - Step only on gated step rising, gate set
// - Step bit low keeps switches and position
// - Effective step is pin AND bit
// - Sense one walks forward table order
// - Sense zero walks reverse table order
// - Reset position A-high B-low, D-high C-low
// - H-bridge never turns both switches on
// - Same-write sense change steps old direction
// - Same-write gate change suppresses step
// - Arrangement bit picks bridge or single
// - Single mode drives each switch directly
// - Single switch bits share one write
// - Battery short on, ground/open off only
// - Overheat goes to thermal warning only
// - Fault codes clear when read starts
// - Summary flag on any output fault
// - Fault code 11 ok,01 open,10 batt,00 gnd
module sbs_sequencer (
    sys_clk,
    sys_rst,
    wr_stb,
    wr_step_bit,
    wr_gate_bit,
    wr_sense_bit,
    wr_arr_bit,
    wr_single_hs,
    wr_single_ls,
    step_pin,
    read_start,
    overtemp_det,
    batt_short_det,
    gnd_short_det,
    open_det,
    hs_on,
    ls_on,
    seq_pos,
    stage_arrangement_select,
    half_bridge_a_fault,
    half_bridge_b_fault,
    half_bridge_c_fault,
    half_bridge_d_fault,
    summary_fault_flag,
    thermal_warning
);
    input wire sys_clk;
    input wire sys_rst;
    input wire wr_stb;
    input wire wr_step_bit;
    input wire wr_gate_bit;
    input wire wr_sense_bit;
    input wire wr_arr_bit;
    input wire [3:0] wr_single_hs;
    input wire [3:0] wr_single_ls;
    input wire step_pin;
    input wire read_start;
    input wire overtemp_det;
    input wire [3:0] batt_short_det;
    input wire [3:0] gnd_short_det;
    input wire [3:0] open_det;
    output reg [3:0] hs_on;
    output reg [3:0] ls_on;
    output reg [1:0] seq_pos;
    output reg stage_arrangement_select;
    output reg [1:0] half_bridge_a_fault;
    output reg [1:0] half_bridge_b_fault;
    output reg [1:0] half_bridge_c_fault;
    output reg [1:0] half_bridge_d_fault;
    output reg summary_fault_flag;
    output reg thermal_warning;

    // ----------------------------------------
    // Control bits held from host writes
    // ----------------------------------------
    reg step_bit_r;
    reg gate_r;
    reg sense_r;
    reg [3:0] single_hs_r;
    reg [3:0] single_ls_r;
    reg pin_s1_r;
    reg pin_s2_r;
    reg eff_step_r;
    reg ot_s1_r;
    reg ot_s2_r;
    reg [3:0] hs_nxt;
    reg [3:0] ls_nxt;
    reg [1:0] pos_nxt;
    wire eff_step;
    wire step_rise;
    wire [3:0] sw_on;
    wire [7:0] codes;
    reg step_dir_r;
    reg [3:0] pair_hs;
    reg [3:0] pair_ls;
    wire hb_mode;
    wire gate_change;
    wire step_load;
    wire step_take;
    wire [3:0] ls_guard;
    wire [3:0] chan_flt;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Pin is asynchronous to the write path
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_s1_r <= 1'h0;
            pin_s2_r <= 1'h0;
            ot_s1_r <= 1'h0;
            ot_s2_r <= 1'h0;
        end else begin
            pin_s1_r <= step_pin;
            pin_s2_r <= pin_s1_r;
            ot_s1_r <= overtemp_det;
            ot_s2_r <= ot_s1_r;
        end
    end

    // ----------------------------------------
    // Effective step
    // ----------------------------------------
    assign eff_step = pin_s2_r & step_bit_r;
    assign step_rise = eff_step & ~eff_step_r;

    // ----------------------------------------
    // Frame decode
    // ----------------------------------------
    // A gate change wins the frame; its step bit is dropped
    assign gate_change = wr_stb & (wr_gate_bit != gate_r);
    assign step_load = wr_stb & ~gate_change;
    assign hb_mode = (stage_arrangement_select == `SBS_ARR_HBRIDGE);
    // Gate and arrangement qualify the step, not the edge detector
    assign step_take = step_rise & gate_r & hb_mode;

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            gate_r <= 1'h0;
            step_bit_r <= 1'h0;
        end else begin
            if (gate_change) begin
                gate_r <= wr_gate_bit;
            end
            if (step_load) begin
                step_bit_r <= wr_step_bit;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            sense_r <= 1'h0;
            stage_arrangement_select <= `SBS_ARR_HBRIDGE;
            single_hs_r <= 4'h0;
            single_ls_r <= 4'h0;
        end else if (wr_stb) begin
            sense_r <= wr_sense_bit;
            stage_arrangement_select <= wr_arr_bit;
            single_hs_r <= wr_single_hs;
            single_ls_r <= wr_single_ls;
        end
    end

    // ----------------------------------------
    // Sequence position
    // ----------------------------------------
    // Sense as it stood an edge ago: a step written with a new sense
    // lands one edge after the write and must still use the old one
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            step_dir_r <= 1'h0;
        end else begin
            step_dir_r <= sense_r;
        end
    end

    always @* begin
        pos_nxt = seq_pos;
        if (step_take) begin
            if (step_dir_r) begin
                pos_nxt = seq_pos + 2'h1;
            end else begin
                pos_nxt = seq_pos - 2'h1;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            seq_pos <= `SBS_POS_RESET;
            eff_step_r <= 1'h0;
        end else begin
            seq_pos <= pos_nxt;
            eff_step_r <= eff_step;
        end
    end

    // ----------------------------------------
    // Switch drive
    // ----------------------------------------
    // Pattern of the position about to be taken, so drive and
    // position move on the same edge
    always @* begin
        {pair_hs, pair_ls} = `SBS_DRV_POS0;
        case (pos_nxt)
            2'h0: begin
                {pair_hs, pair_ls} = `SBS_DRV_POS0;
            end
            2'h1: begin
                {pair_hs, pair_ls} = `SBS_DRV_POS1;
            end
            2'h2: begin
                {pair_hs, pair_ls} = `SBS_DRV_POS2;
            end
            2'h3: begin
                {pair_hs, pair_ls} = `SBS_DRV_POS3;
            end
            default: begin
                {pair_hs, pair_ls} = `SBS_DRV_POS0;
            end
        endcase
    end

    // Belt and braces against shoot-through, per half bridge
    genvar bi;
    generate
        for (bi = 0; bi < 4; bi = bi + 1) begin : g_guard
            assign ls_guard[bi] = pair_ls[bi] & ~pair_hs[bi];
        end
    endgenerate

    always @* begin
        hs_nxt = 4'h0;
        ls_nxt = 4'h0;
        if (!hb_mode) begin
            // No coherency check here: paralleling is the user's call
            hs_nxt = single_hs_r;
            ls_nxt = single_ls_r;
        end else if (gate_r) begin
            hs_nxt = pair_hs;
            ls_nxt = ls_guard;
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            hs_on <= 4'h0;
            ls_on <= 4'h0;
        end else begin
            hs_on <= hs_nxt;
            ls_on <= ls_nxt;
        end
    end

    // ----------------------------------------
    // Diagnosis
    // ----------------------------------------
    assign sw_on = hs_on | ls_on;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_flt
            sbs_fault_cell u_cell (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .read_start(read_start),
                .sw_on(sw_on[gi]),
                .batt_short_det(batt_short_det[gi]),
                .gnd_short_det(gnd_short_det[gi]),
                .open_det(open_det[gi]),
                .code(codes[2*gi+1:2*gi])
            );
            assign chan_flt[gi] = (codes[2*gi+1:2*gi] != `SBS_FLT_NONE);
        end
    endgenerate

    // ----------------------------------------
    // Fault outputs
    // ----------------------------------------
    // Codes and summary registered together so they always agree
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            half_bridge_a_fault <= `SBS_FLT_NONE;
            half_bridge_b_fault <= `SBS_FLT_NONE;
            half_bridge_c_fault <= `SBS_FLT_NONE;
            half_bridge_d_fault <= `SBS_FLT_NONE;
            summary_fault_flag <= 1'h0;
            thermal_warning <= 1'h0;
        end else begin
            half_bridge_a_fault <= codes[1:0];
            half_bridge_b_fault <= codes[3:2];
            half_bridge_c_fault <= codes[5:4];
            half_bridge_d_fault <= codes[7:6];
            summary_fault_flag <= |chan_flt;
            thermal_warning <= ot_s2_r;
        end
    end
endmodule // sbs_sequencer

// ==== core/sbs_regs.vh ====
// Constants for the stepper bridge sequencer
`ifndef SBS_REGS_VH
`define SBS_REGS_VH
// ----------------------------------------
// Sequence positions and reset values
// ----------------------------------------
`define SBS_POS_RESET 2'h0
`define SBS_ARR_HBRIDGE 1'h0
`define SBS_ARR_SINGLE 1'h1
// ----------------------------------------
// Two-bit fault codes
// ----------------------------------------
`define SBS_FLT_NONE 2'h3
`define SBS_FLT_OPEN 2'h1
`define SBS_FLT_BATT 2'h2
`define SBS_FLT_GND 2'h0
// ----------------------------------------
// Switch vector bit positions {d,c,b,a}
// ----------------------------------------
`define SBS_A 0
`define SBS_B 1
`define SBS_C 2
`define SBS_D 3
// ----------------------------------------
// Bridge drive per position as {hs,ls}, each {d,c,b,a}
// ----------------------------------------
`define SBS_DRV_POS0 8'h96
`define SBS_DRV_POS1 8'h5a
`define SBS_DRV_POS2 8'h69
`define SBS_DRV_POS3 8'ha5
`endif

// ==== core/sbs_fault_cell.v ====
// One output channel fault latch with clear-on-read
`timescale 1ns/1ps
`include "sbs_regs.vh"
module sbs_fault_cell (
    sys_clk,
    sys_rst,
    read_start,
    sw_on,
    batt_short_det,
    gnd_short_det,
    open_det,
    code
);
    input wire sys_clk;
    input wire sys_rst;
    input wire read_start;
    input wire sw_on;
    input wire batt_short_det;
    input wire gnd_short_det;
    input wire open_det;
    output reg [1:0] code;

    reg [1:0] det_nxt;

    // ----------------------------------------
    // Detection qualified by switch state
    // ----------------------------------------
    always @* begin
        det_nxt = `SBS_FLT_NONE;
        if (sw_on && batt_short_det) begin
            det_nxt = `SBS_FLT_BATT;
        end else if (!sw_on && gnd_short_det) begin
            det_nxt = `SBS_FLT_GND;
        end else if (!sw_on && open_det) begin
            det_nxt = `SBS_FLT_OPEN;
        end
    end

    // New fault wins over the read clear so none is lost
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            code <= `SBS_FLT_NONE;
        end else if (det_nxt != `SBS_FLT_NONE) begin
            if (code == `SBS_FLT_NONE || code == `SBS_FLT_OPEN ||
                    read_start) begin
                code <= det_nxt;
            end
        end else if (read_start) begin
            code <= `SBS_FLT_NONE;
        end
    end
endmodule // sbs_fault_cell

// ==== verif/sbs_host.sv ====
// Host model: control frames and the step pin
`timescale 1ns/1ps
module sbs_host (
    input wire logic sys_clk,
    output logic wr_stb = 1'b0,
    output logic wr_step_bit = 1'b0,
    output logic wr_gate_bit = 1'b0,
    output logic wr_sense_bit = 1'b0,
    output logic wr_arr_bit = 1'b0,
    output logic [3:0] wr_single_hs = 4'h0,
    output logic [3:0] wr_single_ls = 4'h0,
    output logic step_pin = 1'b1 // Idles high
);
    // --------
    // One frame, then settle; fields scrambled outside the strobe
    // --------
    task automatic send(input logic g, s, n, a, input logic [7:0] sw);
        @(posedge sys_clk);
        wr_stb <= 1'b1;
        {wr_gate_bit, wr_step_bit, wr_sense_bit, wr_arr_bit} <= {g, s, n, a};
        {wr_single_hs, wr_single_ls} <= sw;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        {wr_gate_bit, wr_step_bit, wr_sense_bit, wr_arr_bit} <= ~{g, s, n, a};
        {wr_single_hs, wr_single_ls} <= ~sw;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
endmodule // sbs_host

// ==== verif/sbs_sequencer_chk.sv ====
// Port checker for the stepper bridge sequencer
`timescale 1ns/1ps
module sbs_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wr_stb,
    input wire logic wr_step_bit,
    input wire logic wr_gate_bit,
    input wire logic wr_sense_bit,
    input wire logic step_pin,
    input wire logic [3:0] hs_on,
    input wire logic [3:0] ls_on,
    input wire logic [1:0] seq_pos,
    input wire logic stage_arrangement_select,
    input wire logic [1:0] half_bridge_a_fault,
    input wire logic summary_fault_flag
);
    // --------
    // Shadow of the held frame bits
    // --------
    logic g_q, s_q, sb_q;
    logic [7:0] tbl [4] = '{8'h96, 8'h5a, 8'h69, 8'ha5};
    wire logic hb = !stage_arrangement_select;
    // A gate change in the frame swallows its step
    wire logic may_step = g_q && hb && !(wr_stb && wr_gate_bit != g_q);
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            {g_q, s_q, sb_q} <= 3'h0;
        end else if (wr_stb) begin
            g_q <= wr_gate_bit;
            s_q <= wr_sense_bit;
            if (wr_gate_bit == g_q) begin
                sb_q <= wr_step_bit;
            end
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence pin_held;
        step_pin [*4];
    endsequence
    sequence step_frame;
        wr_stb && wr_step_bit && !sb_q && g_q && wr_gate_bit && hb;
    endsequence
    a_no_shoot: assert property (hb |-> (hs_on & ls_on) == 4'h0)
        else $error("shoot-through");
    a_gate_off: assert property (
        hb && $past(hb) && !g_q && !$past(g_q) |-> {hs_on, ls_on} == 8'h00)
        else $error("drive with gate low");
    a_pair_map: assert property (
        hb && $past(hb) && g_q && $past(g_q) |-> {hs_on, ls_on} == tbl[seq_pos])
        else $error("drive pattern");
    a_pos_dir: assert property ($changed(seq_pos) |-> seq_pos ==
        2'($past(seq_pos) + ($past(s_q, 2) ? 2'h1 : 2'h3)))
        else $error("step direction");
    a_no_refused: assert property (
        $changed(seq_pos) |-> $past(may_step)) else $error("refused step");
    a_step_now: assert property (
        pin_held ##0 step_frame |-> ##2 $changed(seq_pos))
        else $error("no step");
    a_low_hold: assert property (
        pin_held ##0 (wr_stb && !wr_step_bit) |-> ##2 $stable(seq_pos))
        else $error("step on low");
    a_fault_sum: assert property (
        half_bridge_a_fault != 2'h3 |-> ##[0:1] summary_fault_flag)
        else $error("summary flag");
endmodule // sbs_chk
bind sbs_sequencer sbs_chk u_chk (.sys_clk, .sys_rst, .wr_stb, .wr_step_bit,
    .wr_gate_bit, .wr_sense_bit, .step_pin, .hs_on, .ls_on, .seq_pos,
    .stage_arrangement_select, .half_bridge_a_fault, .summary_fault_flag);

// ==== verif/sbs_sequencer_tb.sv ====
// Testbench for the stepper bridge sequencer
`timescale 1ns/1ps
module sbs_sequencer_tb;
    logic sys_clk = 1'b0, sys_rst = 1'b1, read_start = 1'b0;
    logic overtemp_det = 1'b0, d;
    logic [3:0] batt_short_det = 4'h0, gnd_short_det = 4'h0, open_det = 4'h0;
    logic [7:0] sw;
    logic [1:0] pos = 2'h0;
    logic [7:0] tbl [4] = '{8'h96, 8'h5a, 8'h69, 8'ha5};
    wire wr_stb, wr_step_bit, wr_gate_bit, wr_sense_bit, wr_arr_bit, step_pin;
    wire [3:0] wr_single_hs, wr_single_ls, hs_on, ls_on;
    wire [1:0] seq_pos, half_bridge_a_fault;
    wire [1:0] half_bridge_b_fault, half_bridge_c_fault, half_bridge_d_fault;
    wire stage_arrangement_select, summary_fault_flag, thermal_warning;
    int mismatches = 0, compares = 0;
    always #25 sys_clk = ~sys_clk;
    sbs_host h (.sys_clk, .wr_stb, .wr_step_bit, .wr_gate_bit, .wr_sense_bit,
        .wr_arr_bit, .wr_single_hs, .wr_single_ls, .step_pin);
    sbs_sequencer dut (.sys_clk, .sys_rst, .wr_stb, .wr_step_bit,
        .wr_gate_bit, .wr_sense_bit, .wr_arr_bit, .wr_single_hs,
        .wr_single_ls, .step_pin, .read_start, .overtemp_det,
        .batt_short_det, .gnd_short_det, .open_det, .hs_on, .ls_on,
        .seq_pos, .stage_arrangement_select, .half_bridge_a_fault,
        .half_bridge_b_fault, .half_bridge_c_fault,
        .half_bridge_d_fault, .summary_fault_flag, .thermal_warning);
    // --------
    // Helpers
    // --------
    task automatic chk(input string n, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic logic [1:0] nx(input logic [1:0] p, input logic n);
        return n ? p + 2'h1 : p - 2'h1;
    endfunction
    task automatic drv_ok;
        chk("pos", seq_pos, pos);
        chk("drv", {hs_on, ls_on}, tbl[pos]);
    endtask
    // Pulse one detector set, check the code, then read it away
    task automatic flt(input logic [3:0] b, g, o, input logic [1:0] e);
        @(posedge sys_clk);
        {batt_short_det, gnd_short_det, open_det} <= {b, g, o};
        @(posedge sys_clk);
        {batt_short_det, gnd_short_det, open_det} <= 12'h0;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("fault", half_bridge_a_fault, e);
        chk("flag", summary_fault_flag, e != 2'h3);
        chk("others", {half_bridge_b_fault, half_bridge_c_fault,
            half_bridge_d_fault}, 8'h3f);
        @(posedge sys_clk);
        read_start <= 1'b1;
        @(posedge sys_clk);
        read_start <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("clear", half_bridge_a_fault, 2'h3);
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        void'($urandom(32'haed6e26e));
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        chk("arr", stage_arrangement_select, 1'b0);
        chk("off", {hs_on, ls_on}, 8'h00);
        h.send(1, 0, 1, 0, 8'h00);
        drv_ok;
        for (int i = 0; i < 24; i++) begin
            d = 1'($urandom);
            h.send(1, 0, d, 0, 8'h00);
            h.send(1, 1, d, 0, 8'h00);
            pos = nx(pos, d);
            drv_ok;
            h.send(1, 0, d, 0, 8'h00);
            drv_ok;
        end
        h.send(1, 1, !d, 0, 8'h00);
        pos = nx(pos, d);
        drv_ok;
        d = !d;
        h.send(1, 0, d, 0, 8'h00);
        h.send(0, 1, d, 0, 8'h00);
        chk("off", {hs_on, ls_on}, 8'h00);
        h.send(0, 0, d, 0, 8'h00);
        h.send(1, 1, d, 0, 8'h00);
        drv_ok;
        h.send(1, 0, d, 0, 8'h00);
        @(posedge sys_clk);
        h.step_pin <= 1'b0;
        repeat (3) @(posedge sys_clk);
        h.send(1, 1, d, 0, 8'h00);
        drv_ok;
        @(posedge sys_clk);
        h.step_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        pos = nx(pos, d);
        drv_ok;
        sw = 8'($urandom);
        h.send(1, 0, d, 1, sw);
        chk("arr", stage_arrangement_select, 1'b1);
        chk("single", {hs_on, ls_on}, sw);
        h.send(1, 1, d, 1, sw);
        chk("pos", seq_pos, pos);
        h.send(1, 0, d, 1, 8'h10);
        flt(4'h1, 4'h0, 4'h0, 2'h2);
        flt(4'h0, 4'h1, 4'h0, 2'h3);
        h.send(1, 0, d, 1, 8'h00);
        flt(4'h1, 4'h0, 4'h0, 2'h3);
        flt(4'h0, 4'h1, 4'h0, 2'h0);
        flt(4'h0, 4'h0, 4'h1, 2'h1);
        @(posedge sys_clk);
        overtemp_det <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("therm", thermal_warning, 1'b1);
        chk("flag", summary_fault_flag, 1'b0);
        wrap_up;
    end
    // Cut short a hang well past the expected run
    initial begin
        repeat (4000) @(posedge sys_clk);
        mismatches++;
        wrap_up;
    end
endmodule // sbs_sequencer_tb
